/* design/cmo_compare_match_output.sv */
// output compare channel with AXI4-Lite registers, PWM and fault protection
//
// Overview of operation
// - Compare one of two selected timers
// - Compare against primary or both compare values
// - Change pin on timer equal to compare
// - Three-bit mode field; zero disables channel
// - One-shot and pulse modes start defined level
// - Interrupts follow mode-specific output edges
// - Toggle keeps level, inverts, interrupts both edges
// - PWM entry: pin follows primary non-zero
// - Plain PWM raises no interrupt
// - Fault PWM interrupts on fault falling edge
// - Select bit one picks second timer
// - Fault flag set by hardware, hardware-cleared
// - Idle-stop bit halts channel during idle
// - Delayed one-shot once, continuous pulse repeats
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cmo_compare_match_output
	import cmo_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic cpuIdle,
	input wire logic [15:0] firstTimebase,
	input wire logic [15:0] secondTimebase,
	input wire logic firstRollover,
	input wire logic secondRollover,
	input wire logic gpioPinLevel,
	input wire logic faultInputPin,
	output logic compareOutputPin,
	output logic irq,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// byte-lane merge used for every writable register
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < CMO_STRB_W; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// address decode shared by the write and read paths
	function automatic logic isMapped(input logic [31:0] addr);
		logic [7:0] low;
		low = addr[CMO_DECODE_W-1:0];
		return (addr[31:CMO_DECODE_W] == '0) &&
			(low == CMO_OFF_CTRL || low == CMO_OFF_PRIMARY ||
			low == CMO_OFF_SECONDARY || low == CMO_OFF_INT_STATUS ||
			low == CMO_OFF_INT_MASK || low == CMO_OFF_STATUS);
	endfunction

	// pin level taken on entry to a mode
	function automatic logic initLevel(input cmo_mode_t m, input logic cur,
		input logic gpio, input logic priNonZero);
		logic lvl;
		lvl = 1'b0;
		unique case (m)
			CMO_MODE_OFF: lvl = gpio;
			CMO_MODE_LOW_ONESHOT: lvl = 1'b0;
			CMO_MODE_HIGH_ONESHOT: lvl = 1'b1;
			CMO_MODE_TOGGLE: lvl = cur;
			CMO_MODE_DELAYED: lvl = 1'b0;
			CMO_MODE_CONTINUOUS: lvl = 1'b0;
			CMO_MODE_PWM: lvl = priNonZero;
			CMO_MODE_PWM_FAULT: lvl = priNonZero;
		endcase
		return lvl;
	endfunction

	// which output edges raise the compare interrupt in each mode
	function automatic logic edgeIrq(input cmo_mode_t m, input logic rise,
		input logic fall);
		logic hit;
		hit = 1'b0;
		unique case (m)
			CMO_MODE_OFF: hit = 1'b0;
			CMO_MODE_LOW_ONESHOT: hit = rise;
			CMO_MODE_HIGH_ONESHOT: hit = fall;
			CMO_MODE_TOGGLE: hit = rise | fall;
			CMO_MODE_DELAYED: hit = fall;
			CMO_MODE_CONTINUOUS: hit = fall;
			CMO_MODE_PWM: hit = 1'b0;
			CMO_MODE_PWM_FAULT: hit = 1'b0;
		endcase
		return hit;
	endfunction

	cmo_mode_t modeQ;
	cmo_mode_t modePrevQ;
	logic timebaseSelQ;
	logic idleStopQ;
	logic faultFlagQ;
	logic [15:0] primaryQ;
	logic [15:0] secondaryQ;
	logic [1:0] intStatusQ;
	logic [1:0] intMaskQ;
	logic pinQ, pinD;
	logic doneQ, doneD;

	logic awHeldQ, wHeldQ, bValidQ, rValidQ;
	logic [31:0] awAddrQ, wDataQ, rDataQ;
	logic [3:0] wStrbQ;
	logic [1:0] bRespQ, rRespQ;

	logic faultLevel;
	logic faultFall;

	cmo_pin_sync u_fault_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.pinAsync(faultInputPin),
		.pinLevel(faultLevel),
		.pinFall(faultFall)
	);

	// ---- bus write path ----
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire doWrite = awHeldQ & wHeldQ & ~bValidQ;
	wire [7:0] wrOff = awAddrQ[CMO_DECODE_W-1:0];
	wire wrMapped = isMapped(awAddrQ);
	wire wrCtrl = doWrite & wrMapped & (wrOff == CMO_OFF_CTRL);
	wire wrPri = doWrite & wrMapped & (wrOff == CMO_OFF_PRIMARY);
	wire wrSec = doWrite & wrMapped & (wrOff == CMO_OFF_SECONDARY);
	wire wrIntSts = doWrite & wrMapped & (wrOff == CMO_OFF_INT_STATUS);
	wire wrIntMsk = doWrite & wrMapped & (wrOff == CMO_OFF_INT_MASK);

	wire [31:0] ctrlRead = {18'h00000, idleStopQ, 8'h00, faultFlagQ,
		timebaseSelQ, modeQ};
	wire [31:0] ctrlMerged = mergeBytes(ctrlRead, wDataQ, wStrbQ);
	wire [31:0] priMerged = mergeBytes({16'h0000, primaryQ}, wDataQ, wStrbQ);
	wire [31:0] secMerged = mergeBytes({16'h0000, secondaryQ}, wDataQ, wStrbQ);
	wire [31:0] stsMerged = mergeBytes(32'h00000000, wDataQ, wStrbQ);
	wire [31:0] mskMerged = mergeBytes({30'h00000000, intMaskQ}, wDataQ, wStrbQ);

	// one write at a time: each channel closes once its beat is held
	assign s_axi_awready = ~awHeldQ & ~bValidQ;
	assign s_axi_wready = ~wHeldQ & ~bValidQ;
	assign s_axi_bvalid = bValidQ;
	assign s_axi_bresp = bRespQ;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			awHeldQ <= 1'b0;
			wHeldQ <= 1'b0;
			awAddrQ <= 32'h00000000;
			wDataQ <= 32'h00000000;
			wStrbQ <= 4'h0;
			bValidQ <= 1'b0;
			bRespQ <= CMO_RESP_OKAY;
		end else if (clkEn) begin
			if (awTake) begin
				awHeldQ <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			if (wTake) begin
				wHeldQ <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeldQ <= 1'b0;
				wHeldQ <= 1'b0;
				bValidQ <= 1'b1;
				bRespQ <= wrMapped ? CMO_RESP_OKAY : CMO_RESP_SLVERR;
			end else if (bValidQ && s_axi_bready) begin
				bValidQ <= 1'b0;
			end
		end
	end

	// ---- bus read path ----
	wire [15:0] timerNow = timebaseSelQ ? secondTimebase : firstTimebase;
	wire [7:0] rdOff = s_axi_araddr[CMO_DECODE_W-1:0];
	wire rdMapped = isMapped(s_axi_araddr);
	wire [31:0] statusRead = ({16'h0000, timerNow} << CMO_STS_TIMER_LSB) |
		({31'h00000000, pinQ} << CMO_STS_PIN_BIT);
	wire [31:0] rdMux =
		!rdMapped ? 32'h00000000 :
		(rdOff == CMO_OFF_CTRL) ? ctrlRead :
		(rdOff == CMO_OFF_PRIMARY) ? {16'h0000, primaryQ} :
		(rdOff == CMO_OFF_SECONDARY) ? {16'h0000, secondaryQ} :
		(rdOff == CMO_OFF_INT_STATUS) ? {30'h00000000, intStatusQ} :
		(rdOff == CMO_OFF_INT_MASK) ? {30'h00000000, intMaskQ} :
		statusRead;
	wire arTake = s_axi_arvalid & s_axi_arready;

	assign s_axi_arready = ~rValidQ;
	assign s_axi_rvalid = rValidQ;
	assign s_axi_rdata = rDataQ;
	assign s_axi_rresp = rRespQ;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rValidQ <= 1'b0;
			rDataQ <= 32'h00000000;
			rRespQ <= CMO_RESP_OKAY;
		end else if (clkEn) begin
			if (arTake) begin
				rValidQ <= 1'b1;
				rDataQ <= rdMux;
				rRespQ <= rdMapped ? CMO_RESP_OKAY : CMO_RESP_SLVERR;
			end else if (rValidQ && s_axi_rready) begin
				rValidQ <= 1'b0;
			end
		end
	end

	// ---- channel ----
	// idle-stop freezes the channel only; the bus keeps answering
	wire run = ~(idleStopQ & cpuIdle);
	wire rollover = timebaseSelQ ? secondRollover : firstRollover;
	wire matchPri = (timerNow == primaryQ);
	wire matchSec = (timerNow == secondaryQ);
	wire modeEntry = (modeQ != modePrevQ);
	wire isPwm = (modeQ == CMO_MODE_PWM) || (modeQ == CMO_MODE_PWM_FAULT);
	wire faultEvent = run & faultFall & (modeQ == CMO_MODE_PWM_FAULT);
	wire pwmReload = run & isPwm & rollover & ~modeEntry;

	always_comb begin
		pinD = pinQ;
		doneD = doneQ;
		if (modeEntry) begin
			pinD = initLevel(modeQ, pinQ, gpioPinLevel, primaryQ != CMO_VALUE_RST);
			doneD = 1'b0;
		end else begin
			unique case (modeQ)
				CMO_MODE_OFF: pinD = gpioPinLevel;
				CMO_MODE_LOW_ONESHOT: pinD = matchPri ? 1'b1 : pinQ;
				CMO_MODE_HIGH_ONESHOT: pinD = matchPri ? 1'b0 : pinQ;
				CMO_MODE_TOGGLE: pinD = matchPri ? ~pinQ : pinQ;
				CMO_MODE_DELAYED, CMO_MODE_CONTINUOUS: begin
					// the high phase must be seen before a secondary match ends it
					if (!doneQ) begin
						if (matchSec && pinQ) begin
							pinD = 1'b0;
							doneD = (modeQ == CMO_MODE_DELAYED);
						end else if (matchPri) begin
							pinD = 1'b1;
						end
					end
				end
				CMO_MODE_PWM, CMO_MODE_PWM_FAULT: begin
					// a latched fault holds the pin low until the mode is left
					if (faultFlagQ || faultEvent) begin
						pinD = 1'b0;
					end else if (rollover) begin
						pinD = (secondaryQ != CMO_VALUE_RST);
					end else if (matchPri) begin
						pinD = 1'b0;
					end
				end
			endcase
		end
	end

	wire pinRise = run & ~modeEntry & pinD & ~pinQ;
	wire pinFallEdge = run & ~modeEntry & ~pinD & pinQ;
	wire cmpEvent = edgeIrq(modeQ, pinRise, pinFallEdge);
	wire [1:0] intEvents = {faultEvent, cmpEvent};
	wire [1:0] intClear = wrIntSts ? stsMerged[CMO_INT_W-1:0] : 2'h0;
	// set wins over a write-one clear in the same cycle
	wire [1:0] intStatusD = (intStatusQ & ~intClear) | intEvents;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pinQ <= 1'b0;
			doneQ <= 1'b0;
			modePrevQ <= CMO_MODE_OFF;
		end else if (clkEn && run) begin
			pinQ <= pinD;
			doneQ <= doneD;
			modePrevQ <= modeQ;
		end
	end

	// software writes the control fields; the timer should be stopped first
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeQ <= cmo_mode_t'(CMO_MODE_RST);
			timebaseSelQ <= 1'b0;
			idleStopQ <= 1'b0;
		end else if (clkEn && wrCtrl) begin
			modeQ <= cmo_mode_t'(ctrlMerged[CMO_MODE_LSB +: CMO_MODE_W]);
			timebaseSelQ <= ctrlMerged[CMO_TSEL_BIT];
			idleStopQ <= ctrlMerged[CMO_IDLE_BIT];
		end
	end

	// fault flag ignores software; it clears only when the mode leaves fault PWM
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			faultFlagQ <= 1'b0;
		end else if (clkEn) begin
			if (faultEvent) begin
				faultFlagQ <= 1'b1;
			end else if (modeQ != CMO_MODE_PWM_FAULT) begin
				faultFlagQ <= 1'b0;
			end
		end
	end

	// a bus write to the primary value wins over a rollover reload
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			primaryQ <= CMO_VALUE_RST;
			secondaryQ <= CMO_VALUE_RST;
		end else if (clkEn) begin
			if (wrPri) begin
				primaryQ <= priMerged[CMO_TIMER_W-1:0];
			end else if (pwmReload) begin
				primaryQ <= secondaryQ;
			end
			if (wrSec) begin
				secondaryQ <= secMerged[CMO_TIMER_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			intStatusQ <= CMO_INT_RST;
			intMaskQ <= CMO_INT_RST;
		end else if (clkEn) begin
			intStatusQ <= intStatusD;
			if (wrIntMsk) begin
				intMaskQ <= mskMerged[CMO_INT_W-1:0];
			end
		end
	end

	assign irq = |(intStatusQ & intMaskQ);
	assign compareOutputPin = pinQ;

endmodule // cmo_compare_match_output
`default_nettype wire

/* design/cmo_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ns
`default_nettype none
module cmo_pin_sync
	import cmo_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic pinAsync,
	output logic pinLevel,
	output logic pinFall
);

	logic stage1Q;
	logic stage2Q;
	logic stage3Q;
	logic levelQ;
	logic fallQ;

	// a change is accepted only once the second and third stages agree
	wire agree = (stage2Q == stage3Q);
	wire levelD = agree ? stage3Q : levelQ;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1Q <= CMO_FAULT_IDLE_LEVEL;
			stage2Q <= CMO_FAULT_IDLE_LEVEL;
			stage3Q <= CMO_FAULT_IDLE_LEVEL;
			levelQ <= CMO_FAULT_IDLE_LEVEL;
			fallQ <= 1'b0;
		end else if (clkEn) begin
			stage1Q <= pinAsync;
			stage2Q <= stage1Q;
			stage3Q <= stage2Q;
			levelQ <= levelD;
			fallQ <= levelQ & ~levelD;
		end
	end

	assign pinLevel = levelQ;
	assign pinFall = fallQ;

endmodule // cmo_pin_sync
`default_nettype wire

/* design/cmo_pkg.sv */
// shared constants and types of the compare match output channel
package cmo_pkg;

	localparam int CMO_DATA_W = 32;
	localparam int CMO_TIMER_W = 16;
	localparam int CMO_DECODE_W = 8;
	localparam int CMO_STRB_W = 4;

	// register byte offsets
	localparam logic [7:0] CMO_OFF_CTRL = 8'h00;
	localparam logic [7:0] CMO_OFF_PRIMARY = 8'h04;
	localparam logic [7:0] CMO_OFF_SECONDARY = 8'h08;
	localparam logic [7:0] CMO_OFF_INT_STATUS = 8'h0C;
	localparam logic [7:0] CMO_OFF_INT_MASK = 8'h10;
	localparam logic [7:0] CMO_OFF_STATUS = 8'h14;

	// control register fields
	localparam int CMO_MODE_LSB = 0;
	localparam int CMO_MODE_W = 3;
	localparam int CMO_TSEL_BIT = 3;
	localparam int CMO_FAULT_BIT = 4;
	localparam int CMO_IDLE_BIT = 13;

	// status register fields
	localparam int CMO_STS_PIN_BIT = 0;
	localparam int CMO_STS_TIMER_LSB = 16;

	// interrupt status and mask layout
	localparam int CMO_INT_W = 2;
	localparam int CMO_INT_CMP = 0;
	localparam int CMO_INT_FAULT = 1;

	// reset values
	localparam logic [2:0] CMO_MODE_RST = 3'h0;
	localparam logic [15:0] CMO_VALUE_RST = 16'h0000;
	localparam logic [1:0] CMO_INT_RST = 2'h0;
	localparam logic CMO_FAULT_IDLE_LEVEL = 1'b1;

	localparam logic [1:0] CMO_RESP_OKAY = 2'h0;
	localparam logic [1:0] CMO_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CMO_MODE_OFF = 3'h0,
		CMO_MODE_LOW_ONESHOT = 3'h1,
		CMO_MODE_HIGH_ONESHOT = 3'h2,
		CMO_MODE_TOGGLE = 3'h3,
		CMO_MODE_DELAYED = 3'h4,
		CMO_MODE_CONTINUOUS = 3'h5,
		CMO_MODE_PWM = 3'h6,
		CMO_MODE_PWM_FAULT = 3'h7
	} cmo_mode_t;

endpackage

/* verification/cmo_compare_match_output_tb_top.sv */
// self-checking bench of the compare match output channel
`timescale 1ns/1ns
`default_nettype none
module cmo_compare_match_output_tb_top
	import cmo_pkg::*;
();
	logic clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, cpuIdle = 1'h0, gpioPinLevel = 1'h0;
	logic firstRollover = 1'h0, secondRollover = 1'h0, faultCmd = 1'h0;
	logic [15:0] firstTimebase = 16'h0000, secondTimebase;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, compareOutputPin, irq, faultInputPin;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0, samples_checked = 0, rises;
	// second timer runs 16 counts ahead so a select slip shows up
	assign secondTimebase = firstTimebase + 16'h0010;
	always #50 clk = ~clk;
	cmo_compare_match_output i_dut (.*);
	cmo_load_model i_load (.clk, .pinLevel(compareOutputPin), .faultCmd,
		.faultLine(faultInputPin), .riseCount(rises));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(input logic seen, input logic exp);
		check({31'h0, seen}, {31'h0, exp});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic guard(input int n);
		if (n >= 40) begin
			failures++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n = 0;
		@(posedge clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			guard(n++);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		check({30'h0, s_axi_bresp}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		int n = 0;
		@(posedge clk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			guard(n++);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		check(s_axi_rdata, e);
		check({30'h0, s_axi_rresp}, {30'h0, r});
	endtask
	task automatic run(input int n);
		repeat (n) begin
			@(posedge clk);
			firstTimebase <= firstTimebase + 16'h0001;
		end
		@(posedge clk);
	endtask
	task automatic cfg(input logic [31:0] c, input logic [15:0] p, input logic [15:0] s);
		@(posedge clk);
		firstTimebase <= 16'h0000;
		wr(CMO_OFF_PRIMARY, {16'h0, p});
		wr(CMO_OFF_SECONDARY, {16'h0, s});
		wr(CMO_OFF_CTRL, c);
		wr(CMO_OFF_INT_STATUS, 32'h3);
	endtask
	task automatic t_base();
		// an unmapped write must be refused and leave the control word alone
		wr(8'h40, 32'h7, CMO_RESP_SLVERR);
		rd(CMO_OFF_CTRL, 32'h0);
		rd(8'h40, 32'h0, CMO_RESP_SLVERR);
		gpioPinLevel <= 1'h1;
		run(2);
		chk1(compareOutputPin, 1'h1);
		gpioPinLevel <= 1'h0;
		wr(CMO_OFF_INT_MASK, 32'h3);
	endtask
	task automatic t_shot(input logic [31:0] c, input logic [15:0] p, input logic init);
		cfg(c, p, 16'h0);
		run(3);
		chk1(compareOutputPin, init);
		chk1(irq, 1'h0);
		run(5);
		chk1(compareOutputPin, !init);
		rd(CMO_OFF_STATUS, {init ? 16'h0018 : 16'h0008, 15'h0, !init});
		rd(CMO_OFF_INT_STATUS, 32'h1);
		wr(CMO_OFF_INT_MASK, 32'h2);
		chk1(irq, 1'h0);
		wr(CMO_OFF_INT_MASK, 32'h3);
		chk1(irq, 1'h1);
		wr(CMO_OFF_INT_STATUS, 32'h1);
		chk1(irq, 1'h0);
	endtask
	task automatic t_toggle();
		cfg(32'h3, 16'h0006, 16'h0);
		run(3);
		chk1(compareOutputPin, 1'h0);
		for (int i = 1; i < 3; i++) begin
			cfg(32'h3, 16'h0006, 16'h0);
			run(8);
			chk1(compareOutputPin, i[0]);
			chk1(irq, 1'h1);
		end
	endtask
	task automatic t_pulse(input logic [2:0] m);
		int r;
		cfg({29'h0, m}, 16'h0003, 16'h0006);
		run(2);
		chk1(compareOutputPin, 1'h0);
		run(3);
		chk1(compareOutputPin, 1'h1);
		run(3);
		chk1(compareOutputPin, 1'h0);
		chk1(irq, 1'h1);
		r = rises;
		firstTimebase <= 16'h0000;
		run(8);
		check(32'(rises - r), {31'h0, m == 3'h5});
	endtask
	task automatic t_pwm();
		// second timer selected, so only its rollover may reload the duty
		cfg(32'hE, 16'h0000, 16'h0014);
		run(1);
		chk1(compareOutputPin, 1'h0);
		firstRollover <= 1'h1;
		@(posedge clk);
		firstRollover <= 1'h0;
		@(posedge clk);
		chk1(compareOutputPin, 1'h0);
		secondRollover <= 1'h1;
		@(posedge clk);
		secondRollover <= 1'h0;
		run(1);
		chk1(compareOutputPin, 1'h1);
		run(6);
		chk1(compareOutputPin, 1'h0);
		rd(CMO_OFF_INT_STATUS, 32'h0);
	endtask
	task automatic t_fault();
		cfg(32'h7, 16'h0100, 16'h0100);
		run(1);
		chk1(compareOutputPin, 1'h1);
		faultCmd <= 1'h1;
		run(10);
		chk1(compareOutputPin, 1'h0);
		rd(CMO_OFF_INT_STATUS, 32'h2);
		wr(CMO_OFF_CTRL, 32'h7);
		rd(CMO_OFF_CTRL, 32'h17);
		faultCmd <= 1'h0;
		wr(CMO_OFF_CTRL, 32'h0);
		rd(CMO_OFF_CTRL, 32'h0);
	endtask
	task automatic t_idle();
		cfg(32'h2003, 16'h0006, 16'h0);
		cpuIdle <= 1'h1;
		run(8);
		chk1(compareOutputPin, 1'h0);
		clkEn <= 1'h0;
		@(posedge clk);
		{clkEn, cpuIdle} <= 2'h2;
		firstTimebase <= 16'h0000;
		run(8);
		chk1(compareOutputPin, 1'h1);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		t_base();
		$display("base test ended");
		t_shot(32'h1, 16'h0006, 1'h0);
		$display("low one-shot test ended");
		t_shot(32'hA, 16'h0016, 1'h1);
		$display("high one-shot test ended");
		t_toggle();
		$display("toggle test ended");
		t_pulse(3'h4);
		$display("delayed one-shot test ended");
		t_pulse(3'h5);
		$display("continuous pulse test ended");
		t_pwm();
		$display("pwm test ended");
		t_fault();
		$display("fault test ended");
		t_idle();
		$display("idle test ended");
		stop_test();
	end
endmodule // cmo_compare_match_output_tb_top
`default_nettype wire

/* verification/cmo_load_model.sv */
// load on the output pin; it also drives the fault line
`timescale 1ns/1ns
`default_nettype none
module cmo_load_model
	import cmo_pkg::*;
(
	input wire logic clk,
	input wire logic pinLevel,
	input wire logic faultCmd,
	output logic faultLine,
	output int riseCount
);
	logic lastPin = 1'h0;
	initial riseCount = 0;
	// the fault line has a pull-up, so released it idles high
	assign faultLine = faultCmd ? 1'h0 : CMO_FAULT_IDLE_LEVEL;
	always @(posedge clk) begin
		lastPin <= pinLevel;
		if (pinLevel && !lastPin) begin
			riseCount <= riseCount + 1;
		end
	end
endmodule // cmo_load_model
`default_nettype wire

/* verification/cmo_props.sv */
// port assertions of the compare match output channel
`timescale 1ns/1ns
`default_nettype none
module cmo_props
	import cmo_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic compareOutputPin,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clkEn
			|-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write response late");
	property p_r_after;
		s_axi_arvalid && s_axi_arready && clkEn |=> s_axi_rvalid;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read data late");
	property p_ar_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	property p_aw_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
	// a frozen clock enable must hold the pin and the interrupt line
	property p_freeze;
		!clkEn |=> $stable(compareOutputPin) && $stable(irq);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == CMO_RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read with data");
	c_irq: cover property ($rose(irq));
	c_pin: cover property ($rose(compareOutputPin));
	c_err: cover property (s_axi_rvalid && s_axi_rresp == CMO_RESP_SLVERR);
endmodule // cmo_props
bind cmo_compare_match_output cmo_props i_props (.*);
`default_nettype wire
